/* hw/ivp_arbiter.sv */
/*
 * ivp_arbiter: fixed-priority pick among pending enabled requests.
 * assumes request bit 0 is the highest priority (lowest vector address).
 */
`timescale 1ns/1ps
module ivp_arbiter #(
    parameter int N = 20,
    parameter int IW = 5
) (
    input wire logic [N-1:0] req, // pending and enabled requests
    output logic any, // some request present
    output logic [IW-1:0] idx // index of the winner
);
    // lowest index wins: priority falls as vector address rises
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = IW'(i);
            end
        end
    end
endmodule

/* hw/ivp_controller.sv */
/*
 * ivp_controller: interrupt dispatch: latches 20 source requests, gates
 * them by source enables and the global enable, picks the lowest vector,
 * hands the vector address to the core and tracks the return stack pointer.
 * assumes the core raises vec_accept for one cycle when it takes vec_valid,
 * and return_from_interrupt for one cycle on the return instruction.
 * limitation: one vector is offered at a time; nesting needs software to set gie again.
 */
`timescale 1ns/1ps
module ivp_controller
    import ivp_pkg::*;
#(
    parameter int NUM_SRC = ivp_pkg::IVP_NUM_SRC
) (
    input wire logic mclk, // core clock
    input wire logic rst, // async reset, active high, any reset source
    input wire logic [ivp_pkg::IVP_NUM_SRC-1:0] src_event, // one-cycle source events, index=vector-2
    input wire logic [ivp_pkg::IVP_NUM_SRC-1:0] src_enable, // per-source enable bits
    input wire logic gie_set, // software sets global enable
    input wire logic gie_clear, // software clears global enable
    input wire logic sp_load, // software loads stack pointer
    input wire logic [ivp_pkg::IVP_SP_W-1:0] sp_load_value, // value for sp_load
    input wire logic vec_accept, // core takes the offered vector
    input wire logic return_from_interrupt, // core executes interrupt return
    output logic vec_valid, // vector offered to core
    output logic [ivp_pkg::IVP_ADDR_W-1:0] vec_addr, // offered program word address
    output logic [ivp_pkg::IVP_VEC_W-1:0] vec_num, // offered vector number
    output logic fetch_start, // one cycle: fetch from reset address
    output logic gie, // global enable, status bit 7
    output logic [ivp_pkg::IVP_SP_W-1:0] stack_pointer, // current stack pointer
    output logic [ivp_pkg::IVP_NUM_SRC-1:0] pending // latched requests
);
    import ivp_pkg::*;

    function automatic logic [IVP_ADDR_W-1:0] slot_addr(input logic [IVP_VEC_W-1:0] num);
        slot_addr = IVP_RESET_ADDR + IVP_SLOT_WORDS * IVP_ADDR_W'(num - IVP_RESET_VEC_NUM);
    endfunction

    ivp_state_t state_reg, state_next;
    logic [IVP_NUM_SRC-1:0] pending_reg, pending_next;
    logic gie_reg, gie_next;
    logic [IVP_SP_W-1:0] sp_reg, sp_next;
    logic [IVP_VEC_W-1:0] vnum_reg, vnum_next;
    logic [IVP_ADDR_W-1:0] addr_reg, addr_next;
    logic [IVP_VEC_W-1:0] held_idx_reg, held_idx_next;
    logic valid_reg, valid_next;
    logic start_reg;

    ////////////////////////////////////////////////////////////////////////
    // arbitration, every cycle
    // gie_reg, not its next value, gates the pick: a software set takes effect one cycle later
    wire [IVP_NUM_SRC-1:0] eligible = pending_reg & src_enable & {IVP_NUM_SRC{gie_reg}};
    wire win_any;
    wire [IVP_VEC_W-1:0] win_idx;
    // vector number = source index + 2, reset being vector 1
    wire [IVP_VEC_W-1:0] win_num = win_idx + IVP_RESET_VEC_NUM + 5'h01;
    wire take = (state_reg == IVP_ST_RUN) && win_any;
    wire done = (state_reg == IVP_ST_ISSUE) && vec_accept;
    // only the accepted winner is cleared; every other request keeps waiting
    wire [IVP_NUM_SRC-1:0] done_mask = done ? (IVP_NUM_SRC'(1) << held_idx_reg) : '0;

    ivp_arbiter #(.N(IVP_NUM_SRC), .IW(IVP_VEC_W)) u_arb (
        .req(eligible),
        .any(win_any),
        .idx(win_idx)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    // a new event in the accept cycle keeps the bit pending: set wins
    assign pending_next = (pending_reg & ~done_mask) | src_event;

    always_comb begin
        state_next = state_reg;
        gie_next = gie_reg;
        sp_next = sp_reg;
        vnum_next = vnum_reg;
        addr_next = addr_reg;
        held_idx_next = held_idx_reg;
        valid_next = valid_reg;
        if (gie_set) begin
            gie_next = 1'b1;
        end else if (gie_clear) begin
            gie_next = 1'b0;
        end
        if (sp_load) begin
            sp_next = sp_load_value;
        end
        case (state_reg)
            IVP_ST_RESET: begin
                state_next = IVP_ST_RUN;
            end
            IVP_ST_RUN: begin
                if (take) begin
                    state_next = IVP_ST_ISSUE;
                    vnum_next = win_num;
                    addr_next = slot_addr(win_num);
                    held_idx_next = win_idx;
                    valid_next = 1'b1;
                    gie_next = 1'b0;
                // a return in the cycle of a take is dropped; the core returns only from run
                end else if (return_from_interrupt) begin
                    gie_next = 1'b1;
                    sp_next = sp_reg + IVP_RET_BYTES;
                end
            end
            IVP_ST_ISSUE: begin
                // push applied on accept, so a stalled core never sees the pointer move early
                if (vec_accept) begin
                    state_next = IVP_ST_RUN;
                    valid_next = 1'b0;
                    sp_next = sp_reg - IVP_RET_BYTES;
                end
            end
            default: begin
                state_next = IVP_ST_RESET;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= IVP_ST_RESET;
            pending_reg <= '0;
            gie_reg <= 1'b0;
            sp_reg <= IVP_SP_RESET;
            vnum_reg <= IVP_RESET_VEC_NUM;
            addr_reg <= IVP_RESET_ADDR;
            held_idx_reg <= '0;
            valid_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pending_reg <= pending_next;
            gie_reg <= gie_next;
            sp_reg <= sp_next;
            vnum_reg <= vnum_next;
            addr_reg <= addr_next;
            held_idx_reg <= held_idx_next;
            valid_reg <= valid_next;
            start_reg <= (state_reg == IVP_ST_RESET);
        end
    end

    // address registered beside the number, so the core never sees a decode in flight;
    // it rests at word zero from reset to the first take, which covers fetch_start
    assign vec_addr = addr_reg;
    assign vec_valid = valid_reg;
    assign vec_num = vnum_reg;
    assign fetch_start = start_reg;
    assign gie = gie_reg;
    // no overflow guard: software owns where the stack sits
    assign stack_pointer = sp_reg;
    assign pending = pending_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_gate_global: assert property (@(posedge mclk) disable iff (rst)
        take |-> gie_reg && src_enable[win_idx])
        else $error("vector taken without both enables");
    a_lowest_wins: assert property (@(posedge mclk) disable iff (rst)
        take |-> ((eligible & ((IVP_NUM_SRC'(1) << win_idx) - IVP_NUM_SRC'(1))) == '0))
        else $error("a higher priority request was passed over");
    a_addr_range: assert property (@(posedge mclk) disable iff (rst)
        vec_valid |-> vec_addr > IVP_RESET_ADDR && vec_addr <= IVP_LAST_VEC_ADDR && !vec_addr[0])
        else $error("vector address outside table");
    a_addr_slot: assert property (@(posedge mclk) disable iff (rst)
        $rose(vec_valid) |-> vec_addr == IVP_SLOT_WORDS * IVP_ADDR_W'($past(win_idx) + 5'h01))
        else $error("vector address does not match source");
    a_gie_clear: assert property (@(posedge mclk) disable iff (rst)
        take |=> !gie && vec_valid)
        else $error("global enable not cleared on entry");
    a_gie_return: assert property (@(posedge mclk) disable iff (rst)
        (state_reg == IVP_ST_RUN && !take && return_from_interrupt && !gie_clear) |=> gie)
        else $error("global enable not restored on return");
    a_sp_push: assert property (@(posedge mclk) disable iff (rst)
        (done && !sp_load) |=> stack_pointer == $past(stack_pointer) - IVP_RET_BYTES)
        else $error("stack pointer not lowered by two");
    a_pend_hold: assert property (@(posedge mclk) disable iff (rst)
        (vec_valid && !vec_accept) |=> pending[held_idx_reg] && vec_valid && $stable(vec_addr))
        else $error("request dropped before accept");
    a_reset_fetch: assert property (@(posedge mclk) disable iff (rst)
        fetch_start |-> vec_addr == IVP_RESET_ADDR && !vec_valid)
        else $error("fetch after reset not at word zero");

    // port-side checks: all but a_sp_pop look only at ports, so they still bite if the decode above is wrong
    a_addr_decode: assert property (@(posedge mclk) disable iff (rst)
        vec_valid |-> vec_addr == IVP_SLOT_WORDS * IVP_ADDR_W'(vec_num - IVP_RESET_VEC_NUM))
        else $error("vector address and number disagree");
    a_event_latch: assert property (@(posedge mclk) disable iff (rst)
        (src_event != '0) |=> ((pending & $past(src_event)) == $past(src_event)))
        else $error("source event not latched as pending");
    a_sp_pop: assert property (@(posedge mclk) disable iff (rst)
        (state_reg == IVP_ST_RUN && !take && return_from_interrupt)
            |=> stack_pointer == $past(stack_pointer) + IVP_RET_BYTES)
        else $error("stack pointer not raised by two on return");
    a_fetch_once: assert property (@(posedge mclk) disable iff (rst)
        fetch_start |=> !fetch_start)
        else $error("fetch start held longer than one cycle");
    a_no_take_off: assert property (@(posedge mclk) disable iff (rst)
        (!gie && !vec_valid) |=> !vec_valid)
        else $error("vector offered while global enable was off");
    a_num_hold: assert property (@(posedge mclk) disable iff (rst)
        (vec_valid && !vec_accept) |=> $stable(vec_num))
        else $error("vector number changed before accept");
endmodule

/* hw/ivp_pkg.sv */
/*
 * ivp_pkg: constants for the interrupt vector and priority block.
 * assumes a 16-bit word-addressed program counter and 16-bit stack pointer.
 */
package ivp_pkg;
    localparam int IVP_NUM_SRC = 20;
    localparam int IVP_ADDR_W = 16;
    localparam int IVP_SP_W = 16;
    localparam int IVP_VEC_W = 5;
    // vector numbering: reset is vector 1 at word 0, two words per slot
    localparam logic [IVP_VEC_W-1:0] IVP_RESET_VEC_NUM = 5'h01;
    localparam logic [IVP_ADDR_W-1:0] IVP_RESET_ADDR = 16'h0000;
    localparam logic [IVP_ADDR_W-1:0] IVP_SLOT_WORDS = 16'h0002;
    localparam logic [IVP_ADDR_W-1:0] IVP_LAST_VEC_ADDR = 16'h0028;
    localparam logic [IVP_SP_W-1:0] IVP_RET_BYTES = 16'h0002;
    localparam int IVP_GIE_BIT = 7;
    localparam logic [IVP_SP_W-1:0] IVP_SP_RESET = 16'h0000;
    // source index order = vector number minus two
    localparam int IVP_SRC_EXT0 = 0;
    localparam int IVP_SRC_EXT1 = 1;
    localparam int IVP_SRC_EXT2 = 2;
    localparam int IVP_SRC_T2_MATCH = 3;
    localparam int IVP_SRC_T2_WRAP = 4;
    localparam int IVP_SRC_T1_CAPT = 5;
    localparam int IVP_SRC_T1_MATCH_A = 6;
    localparam int IVP_SRC_T1_MATCH_B = 7;
    localparam int IVP_SRC_T1_WRAP = 8;
    localparam int IVP_SRC_T0_MATCH = 9;
    localparam int IVP_SRC_T0_WRAP = 10;
    localparam int IVP_SRC_SPI = 11;
    localparam int IVP_SRC_RX0 = 12;
    localparam int IVP_SRC_RX1 = 13;
    localparam int IVP_SRC_TXE0 = 14;
    localparam int IVP_SRC_TXE1 = 15;
    localparam int IVP_SRC_TXC0 = 16;
    localparam int IVP_SRC_TXC1 = 17;
    localparam int IVP_SRC_EEPROM = 18;
    localparam int IVP_SRC_COMP = 19;
    typedef enum logic [1:0] {IVP_ST_RESET, IVP_ST_RUN, IVP_ST_ISSUE} ivp_state_t;
endpackage

/* tb/ivp_core_model.sv */
/*
 * ivp_core_model: core side that takes offered vectors after a set stall.
 * assumes vec_valid holds until the edge that samples vec_accept.
 */
`timescale 1ns/1ps
module ivp_core_model (
    input wire logic mclk, // core clock
    input wire logic vec_valid, // vector offered
    input wire logic [4:0] vec_num, // offered number
    input wire logic [15:0] vec_addr, // offered word address
    input wire logic [1:0] wait_cycles, // stall before taking
    output logic vec_accept, // one-cycle take
    output logic [4:0] got_num, // last taken number
    output logic [15:0] got_addr, // last taken address
    output int taken // takes so far
);
    int cnt = 0;
    initial begin
        vec_accept = 1'b0;
        got_num = 5'h00;
        got_addr = 16'h0000;
        taken = 0;
    end
    // held through the sampling edge, dropped only after it
    always @(negedge mclk) begin
        if (vec_accept) begin
            vec_accept <= 1'b0;
            cnt <= 0;
        end else if (vec_valid && cnt >= wait_cycles) begin
            vec_accept <= 1'b1;
        end else if (vec_valid) begin
            cnt <= cnt + 1;
        end
    end
    always @(posedge mclk) begin
        if (vec_accept && vec_valid) begin
            got_num <= vec_num;
            got_addr <= vec_addr;
            taken <= taken + 1;
        end
    end
endmodule

/* tb/testbench.sv */
/*
 * testbench: table-driven run of the interrupt vector block.
 * assumes ivp_core_model stands for the core on the far side.
 */
`timescale 1ns/1ps
module testbench;
    import ivp_pkg::*;
    typedef struct {logic [19:0] ev; logic [19:0] en; logic [4:0] num;} ivp_row_t;
    logic mclk = 1'b0;
    logic rst, gie_set, gie_clear, sp_load, vec_accept, ret, vec_valid, fetch_start, gie;
    logic [19:0] src_event, src_enable, pending;
    logic [15:0] sp_load_value, vec_addr, stack_pointer, got_addr;
    logic [4:0] vec_num, got_num;
    logic [1:0] wait_cycles;
    int taken, fail_count, compares;
    ivp_row_t rows[23];
    ivp_controller uut (.mclk(mclk), .rst(rst), .src_event(src_event), .src_enable(src_enable),
        .gie_set(gie_set), .gie_clear(gie_clear), .sp_load(sp_load), .sp_load_value(sp_load_value),
        .vec_accept(vec_accept), .return_from_interrupt(ret), .vec_valid(vec_valid), .vec_addr(vec_addr),
        .vec_num(vec_num), .fetch_start(fetch_start), .gie(gie), .stack_pointer(stack_pointer), .pending(pending));
    ivp_core_model core (.mclk(mclk), .vec_valid(vec_valid), .vec_num(vec_num), .vec_addr(vec_addr),
        .wait_cycles(wait_cycles), .vec_accept(vec_accept), .got_num(got_num), .got_addr(got_addr), .taken(taken));
    task chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // 48 rounds of returns, then nothing may be left pending; each return re-arms the next take
    task drain;
        src_enable = 20'hfffff;
        repeat (48) begin
            ret = !gie && !vec_valid;
            @(negedge mclk);
            ret = 1'b0;
            repeat (3) @(negedge mclk);
        end
        chk("pending", 20'h0, pending);
        chk("stack_pointer", 20'h00400, 20'(stack_pointer));
    endtask
    task run_row(input ivp_row_t r, input int k);
        int t0;
        t0 = taken;
        wait_cycles = 2'(k % 3);
        src_enable = r.en;
        src_event = r.ev;
        @(negedge mclk);
        src_event = 20'h00000;
        repeat (20) if (taken == t0) @(negedge mclk);
        chk("vec_num", 20'(r.num), 20'(got_num));
        chk("vec_addr", 20'((r.num - 5'h01) * 2), 20'(got_addr));
        chk("gie", 20'h0, 20'(gie));
        chk("stack_pointer", 20'h003fe, 20'(stack_pointer));
        drain;
        $display("row %0d done", k);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 mclk = ~mclk;
    end
    initial begin
        #200us;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        {rst, gie_set, gie_clear, sp_load, ret} = 5'h10;
        src_event = 20'h00000;
        src_enable = 20'h00000;
        sp_load_value = 16'h03fe;
        wait_cycles = 2'h0;
        fail_count = 0;
        compares = 0;
        for (int i = 0; i < 20; i++) rows[i] = '{20'h00001 << i, 20'hfffff, 5'(i + 2)};
        rows[20] = '{20'hfffff, 20'hfffff, 5'h02};
        rows[21] = '{20'h80800, 20'hfffff, 5'h0d};
        rows[22] = '{20'h00030, 20'hfffef, 5'h07};
        repeat (5) @(negedge mclk);
        chk("vec_num", 20'h1, 20'(vec_num));
        chk("vec_addr", 20'h0, 20'(vec_addr));
        rst = 1'b0;
        @(negedge mclk);
        chk("fetch_start", 20'h1, 20'(fetch_start));
        // software loads the stack pointer while enabling source 0, before setting the global enable
        {sp_load, src_enable, src_event} = 41'h1_00001_00001;
        @(negedge mclk);
        chk("fetch_start", 20'h0, 20'(fetch_start));
        {sp_load, src_enable, src_event} = 41'h0;
        gie_set = 1'b1;
        @(negedge mclk);
        {gie_set, gie_clear} = 2'b01;
        @(negedge mclk);
        gie_clear = 1'b0;
        src_enable = 20'h00001;
        repeat (4) @(negedge mclk);
        chk("vec_valid", 20'h0, 20'(vec_valid));
        chk("pending", 20'h1, pending);
        drain;
        $display("reset and refusal done");
        for (int k = 0; k < 23; k++) run_row(rows[k], k);
        // set beats clear when software writes both in one cycle
        gie_clear = 1'b1;
        @(negedge mclk);
        chk("gie", 20'h0, 20'(gie));
        gie_set = 1'b1;
        @(negedge mclk);
        chk("gie", 20'h1, 20'(gie));
        {gie_set, gie_clear} = 2'b00;
        $display("global enable set and clear done");
        // a new event in the accept cycle must survive the clear of its pending bit
        wait_cycles = 2'h0;
        src_event = 20'h00008;
        @(negedge mclk);
        src_event = 20'h00000;
        @(negedge mclk);
        src_event = 20'h00008;
        @(negedge mclk);
        src_event = 20'h00000;
        chk("pending", 20'h00008, pending);
        chk("vec_num", 20'h5, 20'(got_num));
        drain;
        $display("event during accept done");
        src_enable = 20'h00000;
        src_event = 20'h0000f;
        @(negedge mclk);
        {rst, src_event} = 21'h1_00000;
        @(negedge mclk);
        chk("pending", 20'h0, pending);
        chk("gie", 20'h0, 20'(gie));
        chk("stack_pointer", 20'h0, 20'(stack_pointer));
        rst = 1'b0;
        @(negedge mclk);
        chk("fetch_start", 20'h1, 20'(fetch_start));
        chk("vec_addr", 20'h0, 20'(vec_addr));
        chk("vec_num", 20'h1, 20'(vec_num));
        @(negedge mclk);
        chk("fetch_start", 20'h0, 20'(fetch_start));
        chk("vec_valid", 20'h0, 20'(vec_valid));
        $display("mid-run reset done");
        tally_and_finish;
    end
endmodule
